// [emu_brk_regs.svh]
// Register map and constants of the emulator break and trace unit
`ifndef EMU_BRK_REGS_SVH
`define EMU_BRK_REGS_SVH
// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_BRK_BASE   8'h10
// Comparator words fill 0x10 to 0x3F, so the other registers sit above them
`define OFS_SWBRK      8'h50
`define OFS_TRACE_CTL  8'h54
`define OFS_TRACE_PTR  8'h58
`define OFS_TRACE_DAT  8'h5C
`define OFS_RTC        8'h60
`define OFS_MAP_BASE   8'h80
// Comparator block: 3 words per comparator (address, mask, cfg)
`define BRK_STRIDE     8'h0C
// ************************************************************
// Field positions
// ************************************************************
`define CTRL_GO        0
`define CTRL_EXT_EDGE  1
`define CTRL_EXT_EN    2
`define CTRL_ARM       3
`define CTRL_MON_RST   4
`define CTRL_CLK_TGT   5
`define CTRL_ICM1      6
`define CTRL_ICM2      7
`define CFG_EN         0
`define CFG_TYPE_LSB   1
`define SWBRK_EN       8
`define BRK_OPCODE     8'h7F
`define TRACE_DEPTH    2048
`define MAP_BLOCKS     64
`define RD_UNMAPPED    32'hDEAD_0000
`endif

// [emu_brk_pkg.sv]
// Types shared by the emulator break and trace unit
package emu_brk_pkg;
  typedef enum logic [2:0] {
    CYC_FETCH, CYC_MEM, CYC_MRD, CYC_MWR, CYC_IO, CYC_IORD, CYC_IOWR, CYC_EXEC
  } cyc_type_t;
  typedef enum logic [2:0] {
    TRG_END_MON, TRG_BEGIN_MON, TRG_END_EVT, TRG_BEGIN_EVT, TRG_CENTER_EVT, TRG_MULTI_EVT
  } trig_mode_t;
  typedef enum logic [1:0] {
    MAP_USER, MAP_EMU_RW, MAP_EMU_RO, MAP_NONE
  } map_attr_t;
  typedef enum logic [1:0] {
    ST_MONITOR, ST_RUN, ST_STOPPING
  } emu_state_t;
endpackage : emu_brk_pkg

// [emu_brk_trace.sv]
// Break, event trigger, realtime trace and mapping unit of the emulator
//
// Contract
// - Per-1K-block map for program and user memory
// - Four attributes: user, RW, RO, none
// - All 256 I/O ports pass to target
// - Comparators A,B,C,event individually enabled
// - 17-bit address match with per-bit don't-care
// - Comparator qualified by cycle type
// - Event also matches data with don't-care
// - Armed hardware break only after event fired
// - External break on programmable edge
// - Eight software breakpoints, one global enable
// - Fetch of opcode 7FH takes software break
// - Software break leaves registers untouched
// - Bus cycles stored in 2Kx32 trace while the trigger mode has capture on
// - Entry holds address, data, five strobes
// - Six trace trigger modes
// - 32-bit realtime counter during emulation
// - Monitor-break input stops emulation
// - Halt lamp on halt or bus grant
// - Monitor lamp; reset only in monitor
// - In-circuit lamp in mode one or two
// - Clock source select target or internal
// - Rate selector code maps to baud
`timescale 1ns/1ps
`include "emu_brk_regs.svh"
module emu_brk_trace
  import emu_brk_pkg::*;
#(
  parameter int TRACE_DEPTH = `TRACE_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Emulated processor bus, one pulse per completed cycle
  input  wire logic        bus_cycle_end_i,
  input  wire logic [15:0] bus_addr_i,
  input  wire logic        byte_high_qualifier_i,
  input  wire logic [7:0]  target_data_bus_tap_i,
  input  wire logic        memory_request_strobe_i,
  input  wire logic        io_request_strobe_i,
  input  wire logic        rd_strobe_i,
  input  wire logic        wr_strobe_i,
  input  wire logic        opcode_fetch_cycle_i,
  input  wire logic        exec_cycle_i,
  input  wire logic        cpu_halted_i,
  input  wire logic        bus_grant_ack_i,
  // Front panel and probes (asynchronous)
  input  wire logic        ext_break_pin_i,
  input  wire logic        monitor_break_sw_i,
  input  wire logic        reset_sw_i,
  input  wire logic [3:0]  rate_select_i,
  // Emulation control
  output logic             cpu_run_o,
  output logic             target_clock_source_o,
  output logic             target_io_enable_o,
  output logic             map_user_sel_o,
  output logic             map_write_block_o,
  output logic             map_absent_o,
  output logic             monitor_reset_o,
  output logic [15:0]      baud_divisor_o,
  output logic             rate_invalid_o,
  // Lamps
  output logic             halt_lamp_o,
  output logic             monitor_lamp_o,
  output logic             incircuit_lamp_o
);
  localparam int PW = $clog2(TRACE_DEPTH);
  initial begin
    if (TRACE_DEPTH < 4 || (TRACE_DEPTH & (TRACE_DEPTH - 1)) != 0)
      $error("TRACE_DEPTH must be a power of two of at least 4");
  end

  // ************************************************************
  // Synchronisers
  // ************************************************************
  logic [1:0] ext_s_q, mbrk_s_q, rst_s_q;
  logic       ext_prev_q, mbrk_prev_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_s_q     <= 2'h0;
      mbrk_s_q    <= 2'h0;
      rst_s_q     <= 2'h0;
      ext_prev_q  <= 1'b0;
      mbrk_prev_q <= 1'b0;
    end else begin
      ext_s_q     <= {ext_s_q[0], ext_break_pin_i};
      mbrk_s_q    <= {mbrk_s_q[0], monitor_break_sw_i};
      rst_s_q     <= {rst_s_q[0], reset_sw_i};
      ext_prev_q  <= ext_s_q[1];
      mbrk_prev_q <= mbrk_s_q[1];
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0]  ctrl_q;
  logic [16:0] cmp_addr_q [4];
  logic [16:0] cmp_care_q [4];
  logic [3:0]  cmp_cfg_q  [4];
  logic [7:0]  evt_data_q, evt_care_q;
  logic [8:0]  sw_q;
  logic [2:0]  trig_q;
  logic [1:0]  map_q [2][`MAP_BLOCKS];

  function automatic logic cmp_hit(input logic [16:0] val, input logic [16:0] ref_v,
                                   input logic [16:0] care);
    cmp_hit = ((val ^ ref_v) & care) == 17'h0;
  endfunction : cmp_hit

  function automatic logic [16:0] reg_ofs(input int idx, input int word);
    reg_ofs = 17'(`OFS_BRK_BASE + idx * `BRK_STRIDE + word * 4);
  endfunction : reg_ofs

  wire wr_hit = avs_write_i && !avs_waitrequest_o;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q     <= 8'h00;
      evt_data_q <= 8'h00;
      evt_care_q <= 8'h00;
      sw_q       <= 9'h000;
      trig_q     <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        cmp_addr_q[i] <= 17'h0;
        cmp_care_q[i] <= 17'h0;
        cmp_cfg_q[i]  <= 4'h0;
      end
      for (int b = 0; b < `MAP_BLOCKS; b++) begin
        map_q[0][b] <= MAP_EMU_RW;
        map_q[1][b] <= MAP_USER;
      end
    end else if (wr_hit) begin
      if (avs_address_i == `OFS_CTRL)
        ctrl_q <= avs_writedata_i[7:0];
      if (avs_address_i == `OFS_SWBRK)
        sw_q <= avs_writedata_i[8:0];
      if (avs_address_i == `OFS_TRACE_CTL)
        trig_q <= avs_writedata_i[2:0];
      for (int i = 0; i < 4; i++) begin
        if ({9'h0, avs_address_i} == reg_ofs(i, 0))
          cmp_addr_q[i] <= avs_writedata_i[16:0];
        if ({9'h0, avs_address_i} == reg_ofs(i, 1))
          cmp_care_q[i] <= avs_writedata_i[16:0];
        if ({9'h0, avs_address_i} == reg_ofs(i, 2)) begin
          cmp_cfg_q[i] <= avs_writedata_i[3:0];
          if (i == 3) begin
            evt_data_q <= avs_writedata_i[15:8];
            evt_care_q <= avs_writedata_i[23:16];
          end
        end
      end
      // Map words: bit 6 selects program or user table
      if (avs_address_i[7] == 1'b1)
        map_q[avs_address_i[6]][avs_address_i[5:0]] <= avs_writedata_i[1:0];
    end
  end

  // ************************************************************
  // Comparators and break sources
  // ************************************************************
  wire [16:0] bus_key = {byte_high_qualifier_i, bus_addr_i};
  logic [3:0] cmp_match;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logic ty;
      ty = 1'b0;
      case (cyc_type_t'(cmp_cfg_q[i][3:1]))
        CYC_FETCH: ty = opcode_fetch_cycle_i;
        CYC_MEM:   ty = memory_request_strobe_i;
        CYC_MRD:   ty = memory_request_strobe_i && rd_strobe_i;
        CYC_MWR:   ty = memory_request_strobe_i && wr_strobe_i;
        CYC_IO:    ty = io_request_strobe_i;
        CYC_IORD:  ty = io_request_strobe_i && rd_strobe_i;
        CYC_IOWR:  ty = io_request_strobe_i && wr_strobe_i;
        CYC_EXEC:  ty = exec_cycle_i;
        default:   ty = 1'b0;
      endcase
      cmp_match[i] = bus_cycle_end_i && cmp_cfg_q[i][`CFG_EN] && ty &&
                     cmp_hit(bus_key, cmp_addr_q[i], cmp_care_q[i]);
    end
  end
  wire evt_fire = cmp_match[3] && (((target_data_bus_tap_i ^ evt_data_q) & evt_care_q) == 8'h00);

  logic       armed_q;
  emu_state_t st_q;
  wire running = (st_q == ST_RUN);
  always_ff @(posedge clk_i) begin
    if (srst_i)
      armed_q <= 1'b0;
    else if (!running)
      armed_q <= 1'b0;
    else if (evt_fire)
      armed_q <= 1'b1;
  end

  wire hw_brk = |cmp_match[2:0] && (!ctrl_q[`CTRL_ARM] || armed_q);
  wire ext_edge = ctrl_q[`CTRL_EXT_EDGE] ? (ext_s_q[1] && !ext_prev_q) : (!ext_s_q[1] && ext_prev_q);
  wire ext_brk  = ctrl_q[`CTRL_EXT_EN] && ext_edge;
  // Software break on fetch of breakpoint opcode
  wire sw_brk = sw_q[`SWBRK_EN] && (|sw_q[7:0]) && bus_cycle_end_i && opcode_fetch_cycle_i &&
                target_data_bus_tap_i == `BRK_OPCODE;
  wire mon_brk = mbrk_s_q[1] && !mbrk_prev_q;
  wire any_brk = hw_brk || ext_brk || sw_brk || mon_brk;

  // ************************************************************
  // Run control
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= ST_MONITOR;
    end else begin
      case (st_q)
        ST_MONITOR: if (wr_hit && avs_address_i == `OFS_CTRL && avs_writedata_i[`CTRL_GO]) st_q <= ST_RUN;
        // Stop waits for end of bus cycle
        ST_RUN:      if (any_brk) st_q <= bus_cycle_end_i ? ST_MONITOR : ST_STOPPING;
        ST_STOPPING: if (bus_cycle_end_i) st_q <= ST_MONITOR;
        default:     st_q <= ST_MONITOR;
      endcase
    end
  end
  // Break only freezes the clock; no register is written
  always_ff @(posedge clk_i) begin
    if (srst_i)
      cpu_run_o <= 1'b0;
    else
      cpu_run_o <= (st_q != ST_MONITOR) && !(st_q == ST_RUN && any_brk && bus_cycle_end_i);
  end

  // ************************************************************
  // Realtime counter and trace
  // ************************************************************
  logic [31:0] rtc_q;
  // Counts emulated cycles, wraps at 32 bits
  always_ff @(posedge clk_i) begin
    if (srst_i)
      rtc_q <= 32'h0;
    else if (running && bus_cycle_end_i)
      rtc_q <= rtc_q + 32'h1;
  end

  logic [31:0]   trace_mem [TRACE_DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW:0]   post_q;
  logic          cap_q, stop_pend_q;
  wire           store = running && cap_q && bus_cycle_end_i;
  always_ff @(posedge clk_i) begin
    if (store)
      trace_mem[wptr_q] <= {3'h0, memory_request_strobe_i, io_request_strobe_i, rd_strobe_i,
                            wr_strobe_i, opcode_fetch_cycle_i, target_data_bus_tap_i, bus_addr_i};
  end
  always_ff @(posedge clk_i) begin
    if (srst_i)
      wptr_q <= '0;
    else if (store)
      wptr_q <= wptr_q + 1'b1;
  end
  // Trigger modes start or stop capture
  wire [2:0] tm = trig_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cap_q       <= 1'b0;
      stop_pend_q <= 1'b0;
      post_q      <= '0;
    end else if (!running) begin
      cap_q       <= (tm == TRG_END_MON || tm == TRG_BEGIN_MON || tm == TRG_END_EVT || tm == TRG_CENTER_EVT);
      stop_pend_q <= 1'b0;
      post_q      <= '0;
    end else if (evt_fire) begin
      case (trig_mode_t'(tm))
        TRG_END_EVT:    cap_q <= 1'b0;
        TRG_BEGIN_EVT:  cap_q <= 1'b1;
        TRG_CENTER_EVT: begin
          stop_pend_q <= 1'b1;
          post_q      <= (PW+1)'(TRACE_DEPTH / 2);
        end
        TRG_MULTI_EVT:  cap_q <= 1'b1;
        default:        cap_q <= cap_q;
      endcase
    end else if (tm == TRG_MULTI_EVT && bus_cycle_end_i) begin
      cap_q <= 1'b0;
    end else if (stop_pend_q && store) begin
      post_q <= post_q - 1'b1;
      if (post_q == (PW+1)'(1))
        cap_q <= 1'b0;
    end
  end
  // ************************************************************
  // Bus slave read path: one wait cycle per access
  // ************************************************************
  logic          wait_q;
  logic [PW-1:0] rptr_q;
  always_ff @(posedge clk_i) begin
    if (srst_i)
      wait_q <= 1'b1;
    else
      wait_q <= !((avs_read_i || avs_write_i) && wait_q);
  end
  assign avs_waitrequest_o = wait_q;
  always_ff @(posedge clk_i) begin
    if (srst_i)
      rptr_q <= '0;
    else if (wr_hit && avs_address_i == `OFS_TRACE_PTR)
      rptr_q <= avs_writedata_i[PW-1:0];
    else if (avs_read_i && !wait_q && avs_address_i == `OFS_TRACE_DAT)
      rptr_q <= rptr_q + 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i)
      avs_readdata_o <= 32'h0;
    else if (avs_read_i && wait_q) begin
      case (avs_address_i)
        `OFS_CTRL:      avs_readdata_o <= {24'h0, ctrl_q};
        `OFS_STATUS:    avs_readdata_o <= {26'h0, cap_q, armed_q, 2'(st_q), cpu_halted_i,
                                           bus_grant_ack_i};
        `OFS_SWBRK:     avs_readdata_o <= {23'h0, sw_q};
        `OFS_TRACE_CTL: avs_readdata_o <= {29'h0, trig_q};
        `OFS_TRACE_PTR: avs_readdata_o <= 32'(wptr_q);
        `OFS_TRACE_DAT: avs_readdata_o <= trace_mem[rptr_q];
        `OFS_RTC:       avs_readdata_o <= rtc_q;
        default: begin
          if (avs_address_i[7])
            avs_readdata_o <= {30'h0, map_q[avs_address_i[6]][avs_address_i[5:0]]};
          else
            avs_readdata_o <= `RD_UNMAPPED;
        end
      endcase
    end
  end

  // ************************************************************
  // Mapping, clocking, baud and lamps
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      map_user_sel_o        <= 1'b0;
      map_write_block_o     <= 1'b0;
      map_absent_o          <= 1'b0;
      target_io_enable_o    <= 1'b0;
      target_clock_source_o <= 1'b0;
      monitor_reset_o       <= 1'b0;
      halt_lamp_o           <= 1'b0;
      monitor_lamp_o        <= 1'b1;
      incircuit_lamp_o      <= 1'b0;
    end else begin
      // Attribute of the addressed block, user select from table 1 and the others from table 0
      map_user_sel_o     <= map_q[1][bus_addr_i[15:10]] == MAP_USER;
      map_write_block_o  <= map_q[0][bus_addr_i[15:10]] == MAP_EMU_RO && wr_strobe_i;
      map_absent_o       <= map_q[0][bus_addr_i[15:10]] == MAP_NONE;
      // Every I/O cycle reaches the target
      target_io_enable_o <= io_request_strobe_i;
      target_clock_source_o <= ctrl_q[`CTRL_CLK_TGT];
      // Reset only while in the monitor
      monitor_reset_o    <= (st_q == ST_MONITOR) && (rst_s_q[1] || ctrl_q[`CTRL_MON_RST]);
      halt_lamp_o        <= cpu_halted_i || bus_grant_ack_i;
      monitor_lamp_o     <= st_q == ST_MONITOR;
      incircuit_lamp_o   <= ctrl_q[`CTRL_ICM1] || ctrl_q[`CTRL_ICM2];
    end
  end

  // Code to baud divisor for a 16x oversampled UART
  function automatic logic [15:0] baud_div(input logic [3:0] code);
    case (code)
      4'h0: baud_div = 16'h0146;
      4'h1: baud_div = 16'h028B;
      4'h2: baud_div = 16'h0516;
      4'h3: baud_div = 16'h0A2C;
      4'h4: baud_div = 16'h1458;
      4'h5: baud_div = 16'h28B1;
      4'h6: baud_div = 16'h5161;
      4'h7: baud_div = 16'hA2C3;
      4'h8: baud_div = 16'hFFFF;
      4'h9: baud_div = 16'hDDF2;
      4'hA: baud_div = 16'hB584;
      4'hB: baud_div = 16'h7A12;
      4'hC: baud_div = 16'h0D90;
      4'hD: baud_div = 16'h0C35;
      default: baud_div = 16'h028B;
    endcase
  endfunction : baud_div
  logic [3:0] rate_s1_q, rate_s2_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rate_s1_q      <= 4'h1;
      rate_s2_q      <= 4'h1;
      baud_divisor_o <= 16'h028B;
      rate_invalid_o <= 1'b0;
    end else begin
      rate_s1_q      <= rate_select_i;
      rate_s2_q      <= rate_s1_q;
      baud_divisor_o <= baud_div(rate_s2_q);
      rate_invalid_o <= rate_s2_q > 4'hD;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_mon_lamp_state: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 monitor_lamp_o == ($past(st_q) == ST_MONITOR)) else $error("monitor lamp wrong");
  a_sw_break_stop: assert property (@(posedge clk_i) disable iff (srst_i)
    running && sw_brk |=> st_q == ST_MONITOR) else $error("software break not taken");
  a_sw_disabled: assert property (@(posedge clk_i) disable iff (srst_i)
    !sw_q[`SWBRK_EN] |-> !sw_brk) else $error("software break while disabled");
  a_arm_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_q[`CTRL_ARM] && !armed_q && !ext_brk && !sw_brk && !mon_brk && running && bus_cycle_end_i
    |=> st_q == ST_RUN) else $error("armed break before event");
  a_stop_cycle_end: assert property (@(posedge clk_i) disable iff (srst_i)
    st_q == ST_STOPPING && !bus_cycle_end_i |=> st_q == ST_STOPPING) else $error("early stop");
  a_rtc_count: assert property (@(posedge clk_i) disable iff (srst_i)
    running && bus_cycle_end_i |=> rtc_q == $past(rtc_q) + 32'h1) else $error("rtc miss");
  a_trace_ptr: assert property (@(posedge clk_i) disable iff (srst_i)
    store |=> wptr_q == $past(wptr_q) + 1'b1) else $error("trace pointer stuck");
  a_reset_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    st_q != ST_MONITOR |=> !monitor_reset_o) else $error("reset outside monitor");
  a_halt_lamp: assert property (@(posedge clk_i) disable iff (srst_i)
    bus_grant_ack_i |=> halt_lamp_o) else $error("halt lamp dark");
endmodule : emu_brk_trace

// [target_bus_model.sv]
// Behavioural model of the emulated processor bus
`timescale 1ns/1ps
module target_bus_model (
  // Clock
  input  wire logic        clk_i,
  // Bus cycle
  output logic             cyc_end_o,
  output logic [15:0]      addr_o,
  output logic [7:0]       data_o,
  output logic             memory_request_strobe_o,
  output logic             io_request_strobe_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic             fetch_o
);
  // ************************************************************
  // Bus cycles
  // ************************************************************
  initial begin
    cyc_end_o = 1'b0;
    addr_o = 16'h0000;
    data_o = 8'h00;
    {memory_request_strobe_o, io_request_strobe_o, rd_o, wr_o, fetch_o} = 5'h00;
  end
  // Kind 0 fetch, 1 mem read, 2 mem write, 3 io read, 4 io write
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic [2:0] k);
    cyc_end_o <= 1'b1;
    addr_o    <= a;
    data_o    <= d;
    memory_request_strobe_o    <= (k < 3'h3);
    io_request_strobe_o    <= (k > 3'h2);
    rd_o      <= (k != 3'h2) && (k != 3'h4);
    wr_o      <= (k == 3'h2) || (k == 3'h4);
    fetch_o   <= (k == 3'h0);
    @(posedge clk_i);
    // Released bus is inverted, so a stale copy can never match
    cyc_end_o <= 1'b0;
    addr_o    <= ~a;
    data_o    <= ~d;
    {memory_request_strobe_o, io_request_strobe_o, rd_o, wr_o, fetch_o} <= 5'h00;
    @(posedge clk_i);
  endtask : cycle
endmodule : target_bus_model

// [emulator_break_trace_unit_tb_top.sv]
// Self-checking testbench of the emulator break and trace unit
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module emulator_break_trace_unit_tb_top;
  import emu_brk_pkg::*;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic        clk_i, srst_i, avr, avw, wq, ce, mq, iq, rs, ws, fe, run, tclk, mlamp, hlamp, ilamp;
  logic        rinv, halted, bus_grant_ack, extb, monb;
  logic [3:0]  rsel;
  logic [7:0]  adr, dat;
  logic [15:0] ba, bdiv;
  logic [31:0] wdat, rdat, rq, r1, r2;
  int          errors = 0;
  int          checked = 0;
  real         br[14] = '{19200.0, 9600.0, 4800.0, 2400.0, 1200.0, 600.0, 300.0, 150.0, 75.0, 110.0,
                          134.5, 200.0, 1800.0, 2000.0};
  real         e;
  target_bus_model bus (.clk_i(clk_i), .cyc_end_o(ce), .addr_o(ba), .data_o(dat), .memory_request_strobe_o(mq),
    .io_request_strobe_o(iq), .rd_o(rs), .wr_o(ws), .fetch_o(fe));
  emu_brk_trace dut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(avr),
    .avs_write_i(avw), .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .bus_cycle_end_i(ce), .bus_addr_i(ba), .byte_high_qualifier_i(1'b0), .target_data_bus_tap_i(dat),
    .memory_request_strobe_i(mq), .io_request_strobe_i(iq), .rd_strobe_i(rs), .wr_strobe_i(ws),
    .opcode_fetch_cycle_i(fe), .exec_cycle_i(1'b0), .cpu_halted_i(halted), .bus_grant_ack_i(bus_grant_ack),
    .ext_break_pin_i(extb), .monitor_break_sw_i(monb), .reset_sw_i(1'b0), .rate_select_i(rsel),
    .cpu_run_o(run), .target_clock_source_o(tclk), .target_io_enable_o(), .map_user_sel_o(),
    .map_write_block_o(), .map_absent_o(), .monitor_reset_o(), .baud_divisor_o(bdiv),
    .rate_invalid_o(rinv), .halt_lamp_o(hlamp), .monitor_lamp_o(mlamp), .incircuit_lamp_o(ilamp));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_sim();
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Request held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr  <= a;
    wdat <= d;
    avw  <= w;
    avr  <= ~w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wq !== 1'b0);
    rq = rdat;
    avw <= 1'b0;
    avr <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic w6();
    repeat (6) @(posedge clk_i);
  endtask : w6
  task automatic go(input logic [31:0] c);
    xfer(1'b1, 8'h00, c | 32'h1);
    w6();
    `CHK(run, 1'b1)
    `CHK(mlamp, 1'b0)
  endtask : go
  task automatic stopchk(input logic r);
    w6();
    `CHK(run, r)
    `CHK(mlamp, ~r)
  endtask : stopchk
  // A stop raised between bus cycles waits for the next cycle to end
  task automatic monstop();
    monb <= 1'b1;
    repeat (4) @(posedge clk_i);
    monb <= 1'b0;
    bus.cycle(16'h0000, 8'h00, 3'h1);
    stopchk(1'b0);
  endtask : monstop
  task automatic t_rate();
    for (int i = 0; i < 16; i++) begin
      rsel <= i[3:0];
      repeat (4) @(posedge clk_i);
      `CHK(rinv, i > 13)
      if (i < 14) begin
        e = 100.0e6 / (16.0 * br[i]);
        if (e > 65535.0) e = 65535.0;
        `CHK(bdiv, 16'($rtoi(e + 0.5)))
      end
    end
    rsel <= 4'h1;
  endtask : t_rate
  task automatic t_regs();
    `CHK(mlamp, 1'b1)
    `CHK(run, 1'b0)
    xfer(1'b1, 8'h00, 32'h60);
    xfer(1'b0, 8'h00, 32'h0);
    `CHK(rq, 32'h60)
    `CHK(tclk, 1'b1)
    `CHK(ilamp, 1'b1)
    xfer(1'b0, 8'h08, 32'h0);
    `CHK(rq, 32'hDEAD_0000)
    xfer(1'b1, 8'hC3, 32'h2);
    xfer(1'b0, 8'hC3, 32'h0);
    `CHK(rq, 32'h2)
    xfer(1'b1, 8'h00, 32'h0);
    @(posedge clk_i);
    `CHK(ilamp, 1'b0)
  endtask : t_regs
  task automatic t_brk();
    xfer(1'b1, 8'h50, 32'h001);
    go(32'h0);
    bus.cycle(16'h1234, 8'h7F, 3'h0);
    stopchk(1'b1);
    monstop();
    xfer(1'b1, 8'h50, 32'h101);
    go(32'h0);
    bus.cycle(16'h1234, 8'h7F, 3'h0);
    stopchk(1'b0);
    xfer(1'b1, 8'h10, 32'h4000);
    xfer(1'b1, 8'h14, 32'h1FFFF);
    xfer(1'b1, 8'h18, 32'h7);
    go(32'h0);
    bus.cycle(16'h4000, 8'h00, 3'h1);
    stopchk(1'b1);
    bus.cycle(16'h4000, 8'h00, 3'h2);
    stopchk(1'b0);
    xfer(1'b1, 8'h34, 32'h5000);
    xfer(1'b1, 8'h38, 32'h1FFFF);
    xfer(1'b1, 8'h3C, 32'h5);
    go(32'h8);
    bus.cycle(16'h4000, 8'h00, 3'h2);
    stopchk(1'b1);
    bus.cycle(16'h5000, 8'h00, 3'h1);
    bus.cycle(16'h4000, 8'h00, 3'h2);
    stopchk(1'b0);
    xfer(1'b1, 8'h18, 32'h0);
    go(32'h6);
    extb <= 1'b1;
    repeat (4) @(posedge clk_i);
    bus.cycle(16'h0000, 8'h00, 3'h1);
    stopchk(1'b0);
    go(32'h4);
    extb <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus.cycle(16'h0000, 8'h00, 3'h1);
    stopchk(1'b0);
  endtask : t_brk
  task automatic t_misc();
    halted <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(hlamp, 1'b1)
    halted <= 1'b0;
    bus_grant_ack  <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(hlamp, 1'b1)
    bus_grant_ack <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(hlamp, 1'b0)
    xfer(1'b0, 8'h60, 32'h0);
    r1 = rq;
    xfer(1'b0, 8'h58, 32'h0);
    r2 = rq;
    go(32'h0);
    repeat (3) bus.cycle(16'h2000, 8'h00, 3'h1);
    monstop();
    xfer(1'b0, 8'h60, 32'h0);
    `CHK(rq, r1 + 32'h3)
    xfer(1'b0, 8'h58, 32'h0);
    `CHK(rq, r2 + 32'h3)
    xfer(1'b1, 8'h58, r2);
    xfer(1'b0, 8'h5C, 32'h0);
    `CHK(rq, 32'h1400_2000)
    go(32'h0);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(run, 1'b0)
    `CHK(mlamp, 1'b1)
  endtask : t_misc
  // ************************************************************
  // Sequence and watchdog
  // ************************************************************
  initial begin
    {avr, avw, halted, bus_grant_ack, extb, monb} <= 6'h00;
    adr    <= 8'h00;
    wdat   <= 32'h0;
    rsel   <= 4'h1;
    srst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_brk();
    t_misc();
    t_rate();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_sim();
  end
endmodule : emulator_break_trace_unit_tb_top
